// [hdl/sdtx_formatter.sv]
/*
 * transmit protocol path: line number and check word insertion,
 * then scrambling and nrzi coding toward a serializing transceiver.
 * assumes one video word per mclk, source marks the first word of
 * every timing reference, avalon-mm master for control.
 */
// Functional notes
// - accept 20-bit words in HD mode and 10-bit words in SD mode.
// - upper lane luma or link A, lower lane chroma or link B, SD low.
// - HD mode encodes low 11 bits of line number into two words.
// - line number words replace the two words after the EAV XYZ word.
// - same line number words go into luma and chroma lanes.
// - two check words per lane replace the words after line number.
// - separate luma and chroma check accumulators over own lane only.
// - check covers first active word through second line number word.
// - accumulators start at zero, polynomial x^18 + x^5 + x^4 + 1.
// - check update runs bit serially over each word, LSB first.
// - scramble with x^9 + x^4 + 1, then NRZI x + 1, SD and HD.
// - scrambler and NRZI work on 10-bit or 20-bit words.
// - coding runs LSB first per word, state carried across words.
// - SD only builds drop or bypass insertion and check stages.
// - multi standard builds hold both paths and select by standard.
// - double oversample option runs serial side at twice line rate.
// - second serial reference select exists only with rate pair.
// - HD reference is 3FF, 000, 000, then XYZ, counted from marker.
`default_nettype none
`include "sdtx_cfg.svh"
module sdtx_formatter
   import sdtx_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire sdtx_vid_s vid_in,
   input wire logic [10:0] line_number_in,
   output logic [19:0] tx_parallel_out,
   output logic alt_serial_ref_select,
   output logic serial_x2_enable
);
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [17:0] crc_word(input logic [17:0] c,
                                            input logic [9:0] d);
      logic [17:0] r;
      logic fb;
      r = c;
      for (int i = 0; i < `SDTX_LANE_W; i++) begin
         fb = r[0] ^ d[i];
         r = {fb, r[17:1]};
         r[12] = r[12] ^ fb; // reflected x^5 and x^4 taps
         r[13] = r[13] ^ fb;
      end
      return r;
   endfunction

   // scrambler state in [8:0], nrzi level in [9]
   function automatic logic [29:0] code_word(input logic [9:0] st,
                                             input logic [19:0] d,
                                             input logic wide);
      logic [8:0] sr;
      logic lvl;
      logic s;
      logic [19:0] q;
      sr = st[8:0];
      lvl = st[9];
      q = 20'h00000;
      for (int i = 0; i < 20; i++) begin
         if (wide || i < `SDTX_LANE_W) begin
            s = d[i] ^ sr[3] ^ sr[8]; // x^9 + x^4 + 1
            sr = {sr[7:0], s};
            lvl = lvl ^ s; // nrzi x + 1
            q[i] = lvl;
         end
      end
      return {lvl, sr, q};
   endfunction

   // ****************************************
   // control registers and avalon slave
   // ****************************************
   logic [3:0] ctrl_reg, ctrl_next;
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [10:0] ln_seen_reg, ln_seen_next;
   sdtx_crc_s last_crc_reg, last_crc_next;
   sdtx_mode_e mode;
   logic hd_path;
   logic crc_on_reg, crc_on_next;
   logic [31:0] status_word;

   assign mode = sdtx_mode_e'(ctrl_reg[`SDTX_CTRL_MODE_LSB +: 2]);
   // sd only builds never enable the insertion stage
   assign hd_path = `SDTX_HAS_HD &&
                    (mode == SDTX_MODE_HD || mode == SDTX_MODE_3GA);
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
   assign avs_readdata = rdata_reg;
   // last line number, span flag and path flag for software
   assign status_word = {18'h00000,
                         hd_path,
                         crc_on_reg,
                         1'b0,
                         ln_seen_reg};
   assign alt_serial_ref_select =
      `SDTX_HAS_RATE_PAIR & ctrl_reg[`SDTX_CTRL_ALT_REF_BIT];
   // only meaningful with hd path, transceiver doubles its rate
   assign serial_x2_enable = hd_path & ctrl_reg[`SDTX_CTRL_X2_BIT];

   always_comb begin
      ctrl_next = ctrl_reg;
      ack_next = 1'b0;
      rdata_next = rdata_reg;
      if ((avs_read || avs_write) && !ack_reg) begin
         ack_next = 1'b1;
         // read data stands until the next read, writes leave it alone
         if (avs_write && avs_address == `SDTX_OFS_CTRL) begin
            ctrl_next = avs_writedata[3:0];
         end
         if (avs_read) begin
            unique case (avs_address)
               `SDTX_OFS_CTRL: rdata_next = {28'h0000000, ctrl_reg};
               `SDTX_OFS_STATUS: rdata_next = status_word;
               `SDTX_OFS_LUMA_CRC: rdata_next = {14'h0000,
                                                 last_crc_reg.luma};
               `SDTX_OFS_CHROMA_CRC: rdata_next = {14'h0000,
                                                   last_crc_reg.chroma};
               default: rdata_next = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `SDTX_CTRL_RST;
         ack_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         ctrl_reg <= ctrl_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   // ****************************************
   // slot tracking, line number and check insertion
   // ****************************************
   sdtx_slot_e slot_reg, slot_next;
   logic eav_reg, eav_next;
   sdtx_crc_s crc_reg, crc_next;
   logic [19:0] fmt_reg, fmt_next;
   logic [9:0] ln_lo, ln_hi;
   logic [9:0] luma_w, chroma_w;

   // standard line number word layout, bit 9 is inverse of bit 8
   assign ln_lo = {~line_number_in[6], line_number_in[6:0], 2'h0};
   assign ln_hi = {3'h4, line_number_in[10:7], 3'h0};

   always_comb begin
      slot_next = slot_reg;
      eav_next = eav_reg;
      crc_next = crc_reg;
      crc_on_next = crc_on_reg;
      ln_seen_next = ln_seen_reg;
      last_crc_next = last_crc_reg;
      luma_w = vid_in.word[19:10];
      chroma_w = vid_in.word[9:0];
      // marker restarts slot count on the first word
      if (vid_in.trs_start) begin
         slot_next = SDTX_SL_Z1;
      end else begin
         unique case (slot_reg)
            SDTX_SL_LINE: slot_next = SDTX_SL_LINE;
            SDTX_SL_Z1: slot_next = SDTX_SL_Z2;
            SDTX_SL_Z2: slot_next = SDTX_SL_XYZ;
            SDTX_SL_XYZ: begin
               eav_next = vid_in.word[`SDTX_XYZ_H_BIT];
               slot_next = vid_in.word[`SDTX_XYZ_H_BIT] ?
                           SDTX_SL_LN0 : SDTX_SL_LINE;
            end
            SDTX_SL_LN0: slot_next = SDTX_SL_LN1;
            SDTX_SL_LN1: slot_next = SDTX_SL_CR0;
            SDTX_SL_CR0: slot_next = SDTX_SL_CR1;
            SDTX_SL_CR1: slot_next = SDTX_SL_LINE;
         endcase
      end
      if (hd_path && eav_reg) begin
         unique case (slot_reg)
            SDTX_SL_LN0: begin
               luma_w = ln_lo;
               chroma_w = ln_lo;
               ln_seen_next = line_number_in;
            end
            SDTX_SL_LN1: begin
               luma_w = ln_hi;
               chroma_w = ln_hi;
            end
            SDTX_SL_CR0: begin
               luma_w = {~crc_reg.luma[8], crc_reg.luma[8:0]};
               chroma_w = {~crc_reg.chroma[8], crc_reg.chroma[8:0]};
            end
            SDTX_SL_CR1: begin
               luma_w = {~crc_reg.luma[17], crc_reg.luma[17:9]};
               chroma_w = {~crc_reg.chroma[17], crc_reg.chroma[17:9]};
            end
            default: begin
               luma_w = vid_in.word[19:10];
               chroma_w = vid_in.word[9:0];
            end
         endcase
      end
      // span is sav xyz exclusive through ln1 inclusive
      if (crc_on_reg) begin
         crc_next.luma = crc_word(crc_reg.luma, luma_w);
         crc_next.chroma = crc_word(crc_reg.chroma, chroma_w);
      end
      if (!vid_in.trs_start && slot_reg == SDTX_SL_XYZ &&
          !vid_in.word[`SDTX_XYZ_H_BIT]) begin
         crc_on_next = 1'b1;
         crc_next = '0;
      end
      if (eav_reg && slot_reg == SDTX_SL_LN1) begin
         crc_on_next = 1'b0;
         last_crc_next = crc_next;
      end
      if (!hd_path) begin
         crc_on_next = 1'b0; // bypass path skips checking
      end
      fmt_next = {luma_w, chroma_w};
      if (mode == SDTX_MODE_SD) begin
         fmt_next = {10'h000, vid_in.word[9:0]};
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         slot_reg <= SDTX_SL_LINE;
         eav_reg <= 1'b0;
         crc_reg <= '0;
         crc_on_reg <= 1'b0;
         ln_seen_reg <= 11'h000;
         last_crc_reg <= '0;
         fmt_reg <= 20'h00000;
      end else begin
         slot_reg <= slot_next;
         eav_reg <= eav_next;
         crc_reg <= crc_next;
         crc_on_reg <= crc_on_next;
         ln_seen_reg <= ln_seen_next;
         last_crc_reg <= last_crc_next;
         fmt_reg <= fmt_next; // one stage for every mode
      end
   end

   // ****************************************
   // scrambler and nrzi coder
   // ****************************************
   logic [9:0] code_st_reg, code_st_next;
   logic [19:0] out_reg, out_next;
   logic [29:0] coded;
   logic wide;

   // 3g level a, 3g level b and hd use both lanes, sd only the low lane
   assign wide = (mode != SDTX_MODE_SD) || !`SDTX_HAS_SD;
   assign tx_parallel_out = out_reg;

   always_comb begin
      coded = code_word(code_st_reg, fmt_reg, wide);
      code_st_next = coded[29:20]; // carried into next word
      out_next = coded[19:0];
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         code_st_reg <= 10'h000;
         out_reg <= 20'h00000;
      end else begin
         code_st_reg <= code_st_next;
         out_reg <= out_next; // second and last stage
      end
   end
endmodule
`default_nettype wire

// [hdl/sdtx_cfg.svh]
/*
 * constants of the transmit line formatter and scrambler.
 * assumes inclusion by bare name from hdl files.
 */
`ifndef SDTX_CFG_SVH
`define SDTX_CFG_SVH
// ****************************************
// register map (byte addresses)
// ****************************************
`define SDTX_OFS_CTRL 4'h0
`define SDTX_OFS_STATUS 4'h4
`define SDTX_OFS_LUMA_CRC 4'h8
`define SDTX_OFS_CHROMA_CRC 4'hC
`define SDTX_CTRL_MODE_LSB 0
`define SDTX_CTRL_ALT_REF_BIT 2
`define SDTX_CTRL_X2_BIT 3
`define SDTX_CTRL_RST 4'h1
// ****************************************
// build options
// ****************************************
`define SDTX_HAS_HD 1'b1
`define SDTX_HAS_SD 1'b1
`define SDTX_HAS_RATE_PAIR 1'b1
// ****************************************
// video constants
// ****************************************
`define SDTX_TRS_ONES 10'h3FF
`define SDTX_XYZ_H_BIT 6
`define SDTX_LANE_W 10
`define SDTX_CRC_W 18
`define SDTX_SCR_W 9
`endif

// [hdl/sdtx_pkg.sv]
/*
 * types of the transmit line formatter and scrambler.
 * assumes sdtx_cfg.svh is on the include path.
 */
`default_nettype none
package sdtx_pkg;
   typedef enum logic [1:0] {
      SDTX_MODE_SD = 2'h0,
      SDTX_MODE_HD = 2'h1,
      SDTX_MODE_3GA = 2'h2,
      SDTX_MODE_3GB = 2'h3
   } sdtx_mode_e;
   // slot position inside a timing reference, gray along the path
   typedef enum logic [2:0] {
      SDTX_SL_LINE = 3'h0,
      SDTX_SL_Z1 = 3'h1,
      SDTX_SL_Z2 = 3'h3,
      SDTX_SL_XYZ = 3'h2,
      SDTX_SL_LN0 = 3'h6,
      SDTX_SL_LN1 = 3'h7,
      SDTX_SL_CR0 = 3'h5,
      SDTX_SL_CR1 = 3'h4
   } sdtx_slot_e;
   typedef struct packed {
      logic [19:0] word;
      logic trs_start;
   } sdtx_vid_s;
   typedef struct packed {
      logic [17:0] luma;
      logic [17:0] chroma;
   } sdtx_crc_s;
endpackage
`default_nettype wire

// [bench/sdtx_descrambler.sv]
/* far side model: transceiver nrzi decode and descramble.
   assumes one coded word per mclk from the formatter. */
`default_nettype none
module sdtx_descrambler (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [19:0] coded,
   input wire logic wide,
   output logic [19:0] plain
);
   // ****
   // self synchronising, so no frame lock is needed
   // ****
   logic [8:0] sr_reg;
   logic last_reg;
   always_ff @(posedge mclk or negedge arst_n) begin
      logic [8:0] sr;
      logic lv;
      logic s;
      if (!arst_n) begin
         sr_reg <= '0;
         last_reg <= 1'b0;
         plain <= '0;
      end else begin
         sr = sr_reg;
         lv = last_reg;
         for (int i = 0; i < 20; i++) begin
            if (wide || i < 10) begin
               s = coded[i] ^ lv;
               lv = coded[i];
               plain[i] <= s ^ sr[3] ^ sr[8];
               sr = {sr[7:0], s};
            end else begin
               plain[i] <= 1'b0;
            end
         end
         sr_reg <= sr;
         last_reg <= lv;
      end
   end
endmodule
`default_nettype wire

// [bench/sdtx_checker.sv]
/* port assertions of the formatter.
   assumes the bind below, ctrl shadowed from bus writes. */
`default_nettype none
module sdtx_checker
   import sdtx_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire sdtx_vid_s vid_in,
   input wire logic [10:0] line_number_in,
   input wire logic [19:0] tx_parallel_out,
   input wire logic alt_serial_ref_select,
   input wire logic serial_x2_enable
);
   // ****
   // assertions
   // ****
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   logic [3:0] ctrl_reg;
   logic [3:0] ctrl_next;
   logic ctrl_wr;
   logic rd_done;
   assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == 4'h0;
   assign rd_done = avs_read && !avs_waitrequest;
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrl_wr) begin
         ctrl_next = avs_writedata[3:0];
      end
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= 4'h1;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end
   rd_one_wait_a: assert property ($rose(avs_read) |->
      avs_waitrequest ##1 !avs_waitrequest) else $error("read wait wrong");
   wr_one_wait_a: assert property ($rose(avs_write) |->
      avs_waitrequest ##1 !avs_waitrequest) else $error("write wait wrong");
   idle_no_wait_a: assert property (!avs_read && !avs_write |->
      !avs_waitrequest) else $error("wait while idle");
   unmapped_zero_a: assert property (rd_done && avs_address[1:0] != 2'h0
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   rd_data_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved");
   ctrl_read_a: assert property (
      rd_done && avs_address == 4'h0 |-> avs_readdata[3:0] == ctrl_reg)
      else $error("ctrl readback wrong");
   alt_ref_a: assert property (
      ctrl_wr |=> alt_serial_ref_select == $past(avs_writedata[2]))
      else $error("alt ref select wrong");
   x2_select_a: assert property (
      ctrl_wr |=> serial_x2_enable == ($past(avs_writedata[3]) &&
      (ctrl_reg[1:0] == 2'h1 || ctrl_reg[1:0] == 2'h2)))
      else $error("oversample enable wrong");
   sd_upper_a: assert property (
      ctrl_reg[1:0] == 2'h0 && $past(ctrl_reg[1:0], 3) == 2'h0 |->
      tx_parallel_out[19:10] == 10'h0) else $error("sd upper lane set");
   cover property (ctrl_wr && avs_writedata[1:0] == 2'h0);
   cover property (rd_done && avs_address == 4'h8);
   cover property (vid_in.trs_start ##3 vid_in.word[6]);
endmodule
bind sdtx_formatter sdtx_checker sdtx_checker_inst (.mclk, .arst_n,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
   .avs_waitrequest, .vid_in, .line_number_in, .tx_parallel_out,
   .alt_serial_ref_select, .serial_x2_enable);
`default_nettype wire

// [bench/tb_top.sv]
/* bench: random lines in every mode, registers over avalon.
   assumes the formatter, the descrambler model and the checker bind. */
`default_nettype none
module tb_top
   import sdtx_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // stimulus and checking
   // ****
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   sdtx_vid_s vid_in;
   logic [10:0] line_number_in;
   logic [19:0] tx_parallel_out;
   logic alt_serial_ref_select;
   logic serial_x2_enable;
   logic [19:0] plain;
   logic wide = 1'b1;
   logic [19:0] hist [0:2047];
   bit chkv [0:2047];
   logic [17:0] cy;
   logic [17:0] cc;
   int cyc = 0;
   int error_cnt = 0;
   int check_count = 0;
   sdtx_formatter sdtx_formatter_inst (.mclk, .arst_n, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .vid_in, .line_number_in, .tx_parallel_out,
      .alt_serial_ref_select, .serial_x2_enable);
   sdtx_descrambler sdtx_descrambler_inst (.mclk, .arst_n,
      .coded(tx_parallel_out), .wide, .plain);
   initial forever #25 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] s,
      input logic [31:0] x);
      check_count++;
      if (s !== x) begin
         error_cnt++;
         $display("MISMATCH %s exp %h seen %h", n, x, s);
      end
   endtask
   // coded words reach the model output four counts after driving
   always @(negedge mclk) begin
      if (cyc >= 4 && chkv[cyc - 4]) begin
         check("tx word", 32'(plain), 32'(hist[cyc - 4]));
      end
      if (cyc > 2000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic bus(input bit wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      // waitrequest and read data are taken at the same rising edge
      do begin
         @(posedge mclk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic step(input logic [19:0] w, input bit trs,
      input logic [19:0] e, input bit chk);
      @(posedge mclk);
      vid_in <= sdtx_vid_s'({w, trs});
      hist[cyc] = e;
      chkv[cyc] = chk;
   endtask
   function automatic logic [17:0] crc(logic [17:0] c, logic [9:0] d);
      logic fb;
      for (int i = 0; i < 10; i++) begin
         fb = c[0] ^ d[i];
         c = {fb, c[17:1]};
         c[12] = c[12] ^ fb;
         c[13] = c[13] ^ fb;
      end
      return c;
   endfunction
   task automatic line(input bit ins, input logic [10:0] ln);
      logic [9:0] l0;
      logic [9:0] l1;
      logic [19:0] w;
      logic [19:0] e;
      logic [19:0] m;
      m = wide ? 20'hFFFFF : 20'h003FF;
      l0 = {~ln[6], ln[6:0], 2'b00};
      l1 = {3'b100, ln[10:7], 3'b000};
      line_number_in <= ln;
      for (int k = 0; k < 32; k++) begin
         if (k < 4 || k >= 28) begin
            w = {2{k % 28 == 0 ? 10'h3FF : k == 3 ? 10'h200 :
               k == 31 ? 10'h2D8 : 10'h000}} & m;
         end else begin
            w = 20'($urandom()) & m;
         end
         step(w, k % 28 == 0, w, 1'b1);
         cy = (k == 3) ? 18'h0 : crc(cy, w[19:10]);
         cc = (k == 3) ? 18'h0 : crc(cc, w[9:0]);
      end
      if (ins) begin
         cy = crc(crc(cy, l0), l1);
         cc = crc(crc(cc, l0), l1);
      end
      for (int k = 0; k < 4; k++) begin
         case (k)
            0: e = {l0, l0};
            1: e = {l1, l1};
            2: e = {~cy[8], cy[8:0], ~cc[8], cc[8:0]};
            default: e = {~cy[17], cy[17:9], ~cc[17], cc[17:9]};
         endcase
         w = 20'($urandom()) & m;
         step(w, 1'b0, ins ? e : w, 1'b1);
      end
      repeat (4) step(20'h0, 1'b0, 20'h0, 1'b0);
   endtask
   task automatic results(input logic [10:0] ln);
      logic [31:0] q;
      bus(1'b0, 4'h4, 32'h0, q);
      check("status line", 32'(q[10:0]), 32'(ln));
      check("status flags", 32'(q[13:11]), 32'h4);
      bus(1'b0, 4'h8, 32'h0, q);
      check("luma check", q, 32'(cy));
      bus(1'b0, 4'hC, 32'h0, q);
      check("chroma check", q, 32'(cc));
   endtask
   initial begin
      logic [31:0] q;
      logic [31:0] c;
      logic [1:0] md;
      logic [10:0] ln;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      vid_in = '0;
      line_number_in = 11'h0;
      void'($urandom(32'h3675));
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      bus(1'b0, 4'h0, 32'h0, q);
      check("ctrl reset", q, 32'h1);
      bus(1'b1, 4'h3, 32'hFFFFFFFF, q);
      bus(1'b0, 4'h3, 32'h0, q);
      check("unmapped", q, 32'h0);
      for (int i = 0; i < 4; i++) begin
         md = 2'(i + 1);
         c = 32'({2'(3 - i), md});
         bus(1'b1, 4'h0, c, q);
         bus(1'b0, 4'h0, 32'h0, q);
         check("ctrl", q, c);
         check("alt ref", 32'(alt_serial_ref_select), 32'(c[2]));
         check("x2", 32'(serial_x2_enable),
            32'(c[3] && (md == 2'h1 || md == 2'h2)));
         wide = md != SDTX_MODE_SD;
         repeat (3) step(20'h0, 1'b0, 20'h0, 1'b0);
         ln = 11'($urandom());
         line(md == SDTX_MODE_HD || md == SDTX_MODE_3GA, ln);
         if (md == SDTX_MODE_HD || md == SDTX_MODE_3GA) begin
            results(ln);
         end
      end
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      wide = 1'b1;
      bus(1'b0, 4'h0, 32'h0, q);
      check("ctrl after reset", q, 32'h1);
      repeat (3) step(20'h0, 1'b0, 20'h0, 1'b0);
      line(1'b1, 11'h7FF);
      line(1'b1, 11'h000);
      results(11'h000);
      end_sim();
   end
endmodule
`default_nettype wire
